// ===== tb/motor_brake_sequencer_asserts.sv
module motor_brake_sequencer_asserts #(
    parameter int TICK_CYCLES = 10
) (
    input wire logic       sys_clk,              // Clock
    input wire logic       reset_n,              // Sync reset
    input wire logic       psel,                 // APB select
    input wire logic       penable,              // APB access
    input wire logic       pready,               // APB ready
    input wire logic       pslverr,              // APB error
    input wire logic       driveFault,           // Drive fault
    input wire logic       brake_release_output, // Brake released
    input wire logic       motorPower,           // Power stage on
    input wire logic       commandAccept,        // Commands accepted
    input wire logic       coastActive,          // Fault coast
    input wire logic [2:0] controlMode           // Decoded mode
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    a_fault_drops_all: assert property (driveFault |=> !motorPower && !brake_release_output
        && !commandAccept) else $error("fault left an output on");
    a_fault_coast: assert property (driveFault |=> coastActive)
        else $error("fault without coast");
    a_coast_unpowered: assert property (coastActive |-> !motorPower && !brake_release_output)
        else $error("coast with power or brake");
    a_accept_powered: assert property (commandAccept |-> motorPower)
        else $error("commands accepted unpowered");
    a_accept_after_brake: assert property ($rose(commandAccept) && brake_release_output
        |-> $past(brake_release_output, 8)) else $error("accept too soon after release");
    a_brake_powered: assert property (brake_release_output |-> motorPower)
        else $error("brake released unpowered");
    a_hold_after_brake: assert property ($fell(brake_release_output) && motorPower
        |=> motorPower[*8]) else $error("power dropped right after brake");
    a_power_off_order: assert property ($fell(motorPower) |-> !brake_release_output)
        else $error("power off with brake released");
    a_mode_range: assert property (controlMode <= 3'h6)
        else $error("mode code out of range");
    a_apb_ready: assert property (psel && penable |-> pready)
        else $error("no ready in access");
    a_err_in_access: assert property (pslverr |-> psel && penable)
        else $error("error outside access");

    // Main sequences reached
    cover property ($rose(commandAccept));
    cover property ($fell(brake_release_output) && motorPower);
    cover property ($rose(coastActive));
endmodule

bind motor_brake_sequencer motor_brake_sequencer_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_asserts (
    .sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pready(pready),
    .pslverr(pslverr), .driveFault(driveFault), .brake_release_output(brake_release_output),
    .motorPower(motorPower), .commandAccept(commandAccept), .coastActive(coastActive),
    .controlMode(controlMode));

// ===== tb/motor_brake_sequencer_tb.sv
module motor_brake_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TICK = 10;
    logic        sys_clk, reset_n, psel, penable, pwrite, pready, pslverr;
    logic        servoEnable, driveFault, brakeRelease, motorPower, commandAccept;
    logic        coastActive, spinCmd, er;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] motorSpeed, decelStep;
    logic [2:0]  controlMode;
    logic [31:0] regModel [6] = '{32'hfa, 32'h96, 32'h1e, 32'h1f4, 32'h0, 32'h0};
    logic [2:0]  modeExp [7] = '{3'h0, 3'h6, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5};
    int          n_fail = 0;
    int          comparisons = 0;
    int          seed = 32'h06303f58;
    int          i, n, d;

    motor_brake_sequencer #(.TICK_CYCLES(TICK)) u_motor_brake_sequencer (
        .sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .servoEnable(servoEnable), .driveFault(driveFault),
        .motorSpeed(motorSpeed), .brake_release_output(brakeRelease),
        .motorPower(motorPower), .commandAccept(commandAccept),
        .coastActive(coastActive), .controlMode(controlMode));
    motor_model u_motor_model (.sys_clk(sys_clk), .motorPower(motorPower),
        .brakeRelease(brakeRelease), .spinCmd(spinCmd), .decelStep(decelStep),
        .motorSpeed(motorSpeed));

    initial
    begin
        sys_clk = 0;
        forever #10 sys_clk = ~sys_clk;
    end

    task final_report;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    // Cycle count within a tolerance, since the ms tick phase is free
    task rng(input string what, input int got, input int exp, input int tol);
        check(what, exp, (got >= exp - tol && got <= exp + tol) ? exp : got);
    endtask

    // One APB transfer, held until ready is sampled
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge sys_clk);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1;
        for (i = 0; i < 50 && pready !== 1'b1; i++)
            @(posedge sys_clk);
        if (i == 50)
        begin
            n_fail++;
            final_report;
        end
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    function logic sel(input int w);
        case (w)
            0: return brakeRelease;
            1: return commandAccept;
            default: return motorPower;
        endcase
    endfunction

    task wait_on(input int w, input logic lvl);
        for (n = 1; n < 3000; n++)
        begin
            @(posedge sys_clk);
            #1;
            if (sel(w) === lvl)
                return;
        end
        n_fail++;
        final_report;
    endtask

    task en(input logic v, input logic s);
        @(posedge sys_clk);
        servoEnable <= v;
        spinCmd <= s;
    endtask

    initial
    begin
        {reset_n, psel, penable, pwrite, servoEnable, driveFault, spinCmd} = '0;
        paddr = 0;
        pwdata = 0;
        decelStep = 0;
        repeat (8) @(posedge sys_clk);
        reset_n <= 1;
        for (int k = 0; k < 6; k++)
        begin
            apb(0, 8'(k * 4), 0);
            check("reset value", regModel[k], rd);
            check("read error", 0, er);
        end
        apb(1, 8'h18, 32'h1);
        check("status write error", 1, er);
        apb(0, 8'h1c, 0);
        check("unmapped read error", 1, er);
        apb(1, 8'h00, 32'hffff);
        apb(0, 8'h00, 0);
        check("accept delay clamp", 32'h1f4, rd);
        for (int k = 0; k < 7; k++)
        begin
            apb(1, 8'h10, k);
            repeat (2) @(posedge sys_clk);
            check("control mode", modeExp[k], 32'(controlMode));
        end
        $display("test registers done");
        // No output assigned: no brake, no delays
        en(1, 0);
        wait_on(1, 1);
        check("unassigned brake", 0, brakeRelease);
        en(0, 0);
        wait_on(2, 0);
        rng("unassigned power off", n, 4, 3);
        $display("test unassigned done");
        d = 1 + ($unsigned($random(seed)) % 3);
        apb(1, 8'h14, 32'h90);
        apb(1, 8'h00, d);
        apb(1, 8'h04, 3);
        en(1, 0);
        wait_on(0, 1);
        wait_on(1, 1);
        rng("accept delay", n, d * TICK, 12);
        en(0, 0);
        wait_on(0, 0);
        rng("stationary brake drop", n, 4, 3);
        wait_on(2, 0);
        rng("static hold", n, 3 * TICK, 12);
        $display("test stationary done");
        apb(1, 8'h0c, 5);
        en(1, 0);
        wait_on(1, 1);
        en(1, 1);
        repeat (3) @(posedge sys_clk);
        en(0, 0);
        wait_on(0, 0);
        rng("rotating timeout", n, 5 * TICK + 4, 14);
        wait_on(2, 0);
        rng("rotating hold", n, 50 * TICK, 12);
        apb(1, 8'h0c, 20);
        decelStep <= 1;
        en(1, 0);
        wait_on(1, 1);
        en(1, 1);
        repeat (3) @(posedge sys_clk);
        en(0, 0);
        wait_on(0, 0);
        check("speed at brake drop", 1, motorSpeed <= 16'h001e);
        rng("threshold drop", n, 72, 8);
        wait_on(2, 0);
        $display("test rotating done");
        en(1, 0);
        wait_on(1, 1);
        @(posedge sys_clk);
        driveFault <= 1;
        @(posedge sys_clk);
        #1;
        check("fault power", 0, motorPower);
        check("fault brake", 0, brakeRelease);
        check("fault coast", 1, coastActive);
        en(0, 0);
        driveFault <= 0;
        repeat (8) @(posedge sys_clk);
        check("coast cleared", 0, coastActive);
        $display("test fault done");
        final_report;
    end
endmodule

// ===== tb/motor_model.sv
module motor_model (
    input wire logic        sys_clk,      // Clock
    input wire logic        motorPower,   // Power stage on
    input wire logic        brakeRelease, // Brake released
    input wire logic        spinCmd,      // Host speed command
    input wire logic [15:0] decelStep,    // Speed loss per cycle
    output logic     [15:0] motorSpeed    // Shaft speed, rpm
);
    timeunit 1ns;
    timeprecision 1ps;
    // Engaged brake locks an unpowered shaft; a powered spin command sets 100 rpm; otherwise it coasts down
    always_ff @(posedge sys_clk)
        if (!motorPower && !brakeRelease)
            motorSpeed <= 16'h0000;
        else if (spinCmd && motorPower)
            motorSpeed <= 16'h0064;
        else if (motorSpeed > decelStep)
            motorSpeed <= motorSpeed - decelStep;
        else
            motorSpeed <= 16'h0000;
endmodule

// ===== verilog/brake_seq_pkg.sv
package brake_seq_pkg;

    // Register byte addresses on APB
    localparam logic [7:0] ADDR_ACCEPT_DELAY  = 8'h00;
    localparam logic [7:0] ADDR_STATIC_HOLD   = 8'h04;
    localparam logic [7:0] ADDR_SPEED_LIMIT   = 8'h08;
    localparam logic [7:0] ADDR_ROT_TIMEOUT   = 8'h0c;
    localparam logic [7:0] ADDR_MODE_SELECT   = 8'h10;
    localparam logic [7:0] ADDR_CONTROL       = 8'h14;
    localparam logic [7:0] ADDR_STATUS        = 8'h18;

    // Reset values in ms / rpm
    localparam logic [15:0] RST_ACCEPT_DELAY  = 16'h00fa;
    localparam logic [15:0] RST_STATIC_HOLD   = 16'h0096;
    localparam logic [15:0] RST_SPEED_LIMIT   = 16'h001e;
    localparam logic [15:0] RST_ROT_TIMEOUT   = 16'h01f4;
    localparam logic [15:0] RST_MODE_SELECT   = 16'h0000;

    // Upper limits of the programmable ranges
    localparam logic [15:0] MAX_ACCEPT_DELAY  = 16'h01f4;
    localparam logic [15:0] MAX_SPEED_LIMIT   = 16'h0bb8;
    localparam logic [15:0] MAX_HOLD_TIMEOUT  = 16'h03e8;

    // Stationary/rotating boundary, rpm
    localparam logic [15:0] STATIONARY_RPM    = 16'h0014;
    // Fixed rotating power hold, ms
    localparam logic [15:0] ROT_HOLD_MS       = 16'h0032;

    // Brake release digital output function code
    localparam logic [7:0]  FUNC_BRAKE_REL    = 8'h90;

    // Control register field positions
    localparam int CTL_FUNC_LSB  = 0;
    localparam int CTL_FUNC_MSB  = 7;

    // Tick timing
    localparam int TICK_MS       = 1;
    localparam int CLK_HZ        = 50_000_000;
    localparam int TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;

    // Control mode codes
    typedef enum logic [2:0] {
        MODE_POSITION, MODE_SPEED, MODE_TORQUE,
        MODE_POS_SPEED, MODE_POS_TORQUE, MODE_SPEED_TORQUE, MODE_INVALID
    } ctrl_mode_t;

endpackage

// ===== verilog/motor_brake_sequencer.sv
// Contract
// - Output assigned function 144 signals brake release
// - Wait accept delay after release before commands
// - Stationary stop keeps power for hold delay
// - Programmable speed threshold for rotating stop
// - Programmable timeout from enable off
// - Unassigned brake output disables all brake timing
// - Below 20 rpm selects stationary sequence
// - Stationary stop drops brake output immediately
// - Rotating stop: threshold or timeout, first wins
// - Rotating stop keeps power 50 ms
// - Fault uses separate free-coast brake sequence
// - Mode selector decodes 0,2,3,4,5,6
// - Fault shutdown is free coast only
//
// The APB slave port and the register addresses were chosen for this implementation.
module motor_brake_sequencer #(
    parameter int TICK_CYCLES = brake_seq_pkg::TICK_CYCLES
) (
    input  wire logic        sys_clk,          // 50 MHz system clock
    input  wire logic        reset_n,          // Synchronous reset, active low
    input  wire logic        psel,             // APB select
    input  wire logic        penable,          // APB access phase
    input  wire logic        pwrite,           // APB write
    input  wire logic [7:0]  paddr,            // APB byte address
    input  wire logic [31:0] pwdata,           // APB write data
    output logic      [31:0] prdata,           // APB read data
    output logic             pready,           // APB ready
    output logic             pslverr,          // APB error
    input  wire logic        servoEnable,      // Servo enable pin
    input  wire logic        driveFault,       // Drive fault, same clock
    input  wire logic [15:0] motorSpeed,       // Measured speed, rpm
    output logic             brake_release_output, // Brake release DO
    output logic             motorPower,       // Power stage energised
    output logic             commandAccept,    // Motion commands accepted
    output logic             coastActive,      // Free coast after fault
    output logic [2:0]       controlMode       // Decoded control mode
);

    // Prescaler needs two states and must fit its 26-bit counter
    if (TICK_CYCLES < 2 || TICK_CYCLES > 2 ** 26)
    begin : g_bad_tick
        $error("TICK_CYCLES must lie between 2 and 2**26");
    end

    // Sequencer states; the spare code falls back to off
    typedef enum logic [2:0] {
        ST_OFF, ST_ACCEPT_WAIT, ST_RUN, ST_STATIC_HOLD,
        ST_ROT_WAIT, ST_ROT_HOLD, ST_FAULT
    } seq_t;

    // All state in one word: one comb copy, one register
    typedef struct packed {
        logic [15:0] acceptDelay;
        logic [15:0] staticHold;
        logic [15:0] speedLimit;
        logic [15:0] rotTimeout;
        logic [15:0] modeSelect;
        logic [7:0]  doFunction;
        logic [2:0]  enSync;
        logic        enState;
        seq_t        seq;
        logic [25:0] tickCount;
        logic [15:0] msCount;
        logic [31:0] rdata;
        logic        slvErr;
        logic        brake;
        logic        power;
        logic        accept;
        logic        coast;
        logic [2:0]  mode;
    } state_t;

    // Present and next state, plus decoded strobes
    state_t cur;
    state_t next_cur;
    logic   tick;
    logic   brakeAssigned;
    logic   enRise;
    logic   enFall;
    logic   accessPhase;

    // Handshake is immediate: every access completes in one cycle
    assign accessPhase = psel && penable;
    assign pready      = accessPhase;
    assign prdata      = cur.rdata;
    assign pslverr     = accessPhase && next_cur.slvErr;

    // Outputs straight from flops, no glitches toward the power stage
    assign brake_release_output = cur.brake;
    assign motorPower           = cur.power;
    assign commandAccept        = cur.accept;
    assign coastActive          = cur.coast;
    assign controlMode          = cur.mode;

    // Brake timing only matters with an output carrying the release code
    assign brakeAssigned = (cur.doFunction == brake_seq_pkg::FUNC_BRAKE_REL);
    // Debounced edges: second and third stage must agree
    assign enRise = (cur.enSync[2] == cur.enSync[1]) && cur.enSync[1] && !cur.enState;
    assign enFall = (cur.enSync[2] == cur.enSync[1]) && !cur.enSync[1] && cur.enState;
    assign tick   = (cur.tickCount == 26'(TICK_CYCLES - 1));

    always_comb
    begin
        next_cur        = cur;
        next_cur.slvErr = 1'b0;
        next_cur.enSync = {cur.enSync[1:0], servoEnable};
        if (enRise)
            next_cur.enState = 1'b1;
        else if (enFall)
            next_cur.enState = 1'b0;

        // 1 ms prescaler
        // Ms count saturates so a long wait never wraps under a limit
        next_cur.tickCount = tick ? 26'h0 : cur.tickCount + 26'h1;
        if (tick && cur.msCount != 16'hffff)
            next_cur.msCount = cur.msCount + 16'h1;

        // Register file; out of range timing and speed writes are clamped to the limit, mode select is stored as written
        // Read data captured in setup, so it stands through the access
        if (psel && !penable && !pwrite)
        begin
            unique case (paddr)
                brake_seq_pkg::ADDR_ACCEPT_DELAY: next_cur.rdata = {16'h0, cur.acceptDelay};
                brake_seq_pkg::ADDR_STATIC_HOLD:  next_cur.rdata = {16'h0, cur.staticHold};
                brake_seq_pkg::ADDR_SPEED_LIMIT:  next_cur.rdata = {16'h0, cur.speedLimit};
                brake_seq_pkg::ADDR_ROT_TIMEOUT:  next_cur.rdata = {16'h0, cur.rotTimeout};
                brake_seq_pkg::ADDR_MODE_SELECT:  next_cur.rdata = {16'h0, cur.modeSelect};
                brake_seq_pkg::ADDR_CONTROL:      next_cur.rdata = {24'h0, cur.doFunction};
                brake_seq_pkg::ADDR_STATUS:
                    next_cur.rdata = {24'h0, cur.seq, cur.coast, cur.accept,
                                      cur.power, cur.brake, cur.enState};
                default:                          next_cur.rdata = 32'h0;
            endcase
        end
        // A write lands at the edge that ends its access cycle
        if (accessPhase)
        begin
            if (pwrite)
            begin
                unique case (paddr)
                    brake_seq_pkg::ADDR_ACCEPT_DELAY: next_cur.acceptDelay =
                        (pwdata[15:0] > brake_seq_pkg::MAX_ACCEPT_DELAY) ?
                        brake_seq_pkg::MAX_ACCEPT_DELAY : pwdata[15:0];
                    brake_seq_pkg::ADDR_STATIC_HOLD:  next_cur.staticHold =
                        (pwdata[15:0] > brake_seq_pkg::MAX_HOLD_TIMEOUT) ?
                        brake_seq_pkg::MAX_HOLD_TIMEOUT : pwdata[15:0];
                    brake_seq_pkg::ADDR_SPEED_LIMIT:  next_cur.speedLimit =
                        (pwdata[15:0] > brake_seq_pkg::MAX_SPEED_LIMIT) ?
                        brake_seq_pkg::MAX_SPEED_LIMIT : pwdata[15:0];
                    brake_seq_pkg::ADDR_ROT_TIMEOUT:  next_cur.rotTimeout =
                        (pwdata[15:0] > brake_seq_pkg::MAX_HOLD_TIMEOUT) ?
                        brake_seq_pkg::MAX_HOLD_TIMEOUT : pwdata[15:0];
                    brake_seq_pkg::ADDR_MODE_SELECT:  next_cur.modeSelect = pwdata[15:0];
                    brake_seq_pkg::ADDR_CONTROL:
                        next_cur.doFunction =
                            pwdata[brake_seq_pkg::CTL_FUNC_MSB:brake_seq_pkg::CTL_FUNC_LSB];
                    default:                          next_cur.slvErr = 1'b1;
                endcase
            end
            else if (paddr > brake_seq_pkg::ADDR_STATUS || paddr[1:0] != 2'h0)
                next_cur.slvErr = 1'b1;
        end

        // Control mode decode; code 1 and above 6 are invalid
        unique case (cur.modeSelect)
            16'h0000: next_cur.mode = brake_seq_pkg::MODE_POSITION;
            16'h0002: next_cur.mode = brake_seq_pkg::MODE_SPEED;
            16'h0003: next_cur.mode = brake_seq_pkg::MODE_TORQUE;
            16'h0004: next_cur.mode = brake_seq_pkg::MODE_POS_SPEED;
            16'h0005: next_cur.mode = brake_seq_pkg::MODE_POS_TORQUE;
            16'h0006: next_cur.mode = brake_seq_pkg::MODE_SPEED_TORQUE;
            default:  next_cur.mode = brake_seq_pkg::MODE_INVALID;
        endcase

        // Brake sequencer
        unique case (cur.seq)
            // A fault here only flags coast: nothing is powered to drop
            ST_OFF:
            begin
                next_cur.power  = 1'b0;
                next_cur.accept = 1'b0;
                next_cur.brake  = 1'b0;
                if (!driveFault)
                    next_cur.coast = 1'b0;
                if (enRise && !driveFault)
                begin
                    next_cur.power   = 1'b1;
                    next_cur.brake   = brakeAssigned;
                    next_cur.msCount = 16'h0;
                    next_cur.seq     = brakeAssigned ? ST_ACCEPT_WAIT : ST_RUN;
                    next_cur.accept  = !brakeAssigned;
                end
            end
            ST_ACCEPT_WAIT:
            begin
                // Commands held off so none are lost while the brake lifts
                if (cur.msCount >= cur.acceptDelay)
                begin
                    next_cur.accept = 1'b1;
                    next_cur.seq    = ST_RUN;
                end
                // Enable lost before acceptance: shaft never moved, stop as stationary
                if (enFall)
                begin
                    next_cur.accept = 1'b0;
                    next_cur.brake  = 1'b0;
                    next_cur.msCount = 16'h0;
                    next_cur.seq    = ST_STATIC_HOLD;
                end
            end
            // Speed is judged once, at the moment enable falls
            ST_RUN:
            begin
                if (enFall)
                begin
                    next_cur.accept  = 1'b0;
                    next_cur.msCount = 16'h0;
                    if (!brakeAssigned)
                    begin
                        next_cur.power = 1'b0;
                        next_cur.seq   = ST_OFF;
                    end
                    else if (motorSpeed < brake_seq_pkg::STATIONARY_RPM)
                    begin
                        next_cur.brake = 1'b0;
                        next_cur.seq   = ST_STATIC_HOLD;
                    end
                    else
                        next_cur.seq = ST_ROT_WAIT;
                end
            end
            ST_STATIC_HOLD:
            begin
                // Power held so a vertical load cannot drop before the brake bites
                // Limitation: enable rising again here waits for a fresh toggle
                if (cur.msCount >= cur.staticHold)
                begin
                    next_cur.power = 1'b0;
                    next_cur.seq   = ST_OFF;
                end
            end
            // Timeout caps the wait for a load that never slows down
            ST_ROT_WAIT:
            begin
                if (motorSpeed <= cur.speedLimit || cur.msCount >= cur.rotTimeout)
                begin
                    next_cur.brake   = 1'b0;
                    next_cur.msCount = 16'h0;
                    next_cur.seq     = ST_ROT_HOLD;
                end
            end
            // Fixed hold, not programmable
            ST_ROT_HOLD:
            begin
                if (cur.msCount >= brake_seq_pkg::ROT_HOLD_MS)
                begin
                    next_cur.power = 1'b0;
                    next_cur.seq   = ST_OFF;
                end
            end
            // Leave only once fault and enable are both gone, so a held
            // enable cannot restart the motor straight out of a fault
            ST_FAULT:
            begin
                if (!driveFault && !cur.enState)
                    next_cur.seq = ST_OFF;
            end
            default: next_cur.seq = ST_OFF;
        endcase

        // Fault overrides everything: coast with no delay
        // Placed last so it wins over any sequence step in the same cycle
        if (driveFault)
        begin
            next_cur.power  = 1'b0;
            next_cur.brake  = 1'b0;
            next_cur.accept = 1'b0;
            next_cur.coast  = 1'b1;
            if (cur.seq != ST_OFF)
                next_cur.seq = ST_FAULT;
        end
        else if (cur.seq == ST_FAULT)
            next_cur.coast = 1'b1;
    end

    // State register, synchronous reset
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            // Settings back to defaults, all outputs low
            cur             <= '0;
            cur.acceptDelay <= brake_seq_pkg::RST_ACCEPT_DELAY;
            cur.staticHold  <= brake_seq_pkg::RST_STATIC_HOLD;
            cur.speedLimit  <= brake_seq_pkg::RST_SPEED_LIMIT;
            cur.rotTimeout  <= brake_seq_pkg::RST_ROT_TIMEOUT;
            cur.modeSelect  <= brake_seq_pkg::RST_MODE_SELECT;
            cur.seq         <= ST_OFF;
        end
        else
            cur <= next_cur;
    end

endmodule
